// >>> verilog/overvoltage_protect_irq.sv
// over-power and ac clamp protection with status flags and interrupt pin
`timescale 1ns/100ps
`include "ovp_irq_regs.svh"
module overvoltage_protect_irq
  import ovp_irq_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  // comparator levels, asynchronous to clk
  input  wire logic ovd_above_en,
  input  wire logic ovd_above_dis,
  input  wire logic ovp_above_en,
  input  wire logic ovp_above_dis,
  // host control bits, on the clk domain
  input  wire logic over_power_irq_enable,
  input  wire logic clamp_irq_enable,
  input  wire logic over_power_flag_clear,
  input  wire logic clamp_flag_clear,
  input  wire logic auto_status_clear,
  input  wire logic upper_status_read,
  input  wire logic converter_ov_disable_enable,
  input  wire logic buck_enable_wr,
  input  wire logic buck_enable_wdata,
  // status and control outputs
  output logic      over_power_flag,
  output logic      clamp_flag,
  output logic      buck_converter_enable,
  output logic      ldo_enable,
  // open-drain pin drivers and ac shorts
  output logic      tune_pin_a_out,
  output logic      tune_pin_a_oe_n,
  output logic      tune_pin_b_out,
  output logic      tune_pin_b_oe_n,
  output logic      ac_input_a_short,
  output logic      ac_input_b_short,
  output logic      irq_n_out,
  output logic      irq_n_oe_n
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    // over-power re-arm walk
    arm_state_t arm;
    // synced over-power enable, one cycle late
    logic       ovd_en_prev;
    // tune pins pulled while set
    logic       ovd_hold;
    // ac inputs shorted while set
    logic       clamp_hold;
    // buck converter enable bit
    logic       buck_en;
    // clamp flag, one cycle late
    logic       clamp_flag_prev;
  } top_state_t;
  top_state_t s_q;
  top_state_t s_d;
  logic ovd_en_s;
  logic ovd_dis_s;
  logic ovp_en_s;
  logic ovp_dis_s;
  logic auto_clr;
  flag_if ovd_f ();
  flag_if ovp_f ();
  logic       clamp_rise;
  logic       op_cause;
  logic       clamp_cause;
  logic [1:0] tune_oe_n_v;
  logic [1:0] ac_short_v;
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the shift chain needs two or more stages
  if (`SYNC_STAGES < 2) begin : g_sync_check
    $error("synchroniser needs two or more stages");
  end
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // rising edge of a level against its registered copy
  function automatic logic rose_now(
    input logic cur,
    input logic prev
  );
    return cur & ~prev;
  endfunction
  // hysteresis hold: set above enable, drop below release
  function automatic logic hyst_next(
    input logic hold,
    input logic above_en,
    input logic above_dis
  );
    logic nxt;
    nxt = hold;
    if (above_en) begin
      nxt = 1'b1;
    end else if (!above_dis) begin
      nxt = 1'b0;
    end
    return nxt;
  endfunction
  // re-arm walk: release seen, then a fresh crossing
  function automatic arm_state_t arm_next(
    input arm_state_t cur,
    input logic       set_now,
    input logic       flag_now,
    input logic       above_dis
  );
    arm_state_t nxt;
    nxt = cur;
    case (cur)
      ARM_IDLE: begin
        if (set_now) begin
          nxt = ARM_PENDING;
        end
      end
      ARM_PENDING: begin
        if (!flag_now) begin
          nxt = above_dis ? ARM_WAIT_LOW : ARM_IDLE;
        end
      end
      ARM_WAIT_LOW: begin
        if (!above_dis) begin
          nxt = ARM_IDLE;
        end
      end
      default: begin
        nxt = ARM_IDLE;
      end
    endcase
    return nxt;
  endfunction
  // buck enable: host write, auto disable on clamp rise wins
  function automatic logic buck_next(
    input logic cur,
    input logic wr,
    input logic wdata,
    input logic clamp_rise_now,
    input logic ov_dis,
    input logic clamp_ie
  );
    logic nxt;
    nxt = cur;
    if (wr) begin
      nxt = wdata;
    end
    if (clamp_rise_now & ov_dis & clamp_ie) begin
      nxt = 1'b0;
    end
    return nxt;
  endfunction
  // an enabled source stays pending while flagged or held
  function automatic logic irq_cause(
    input logic enable,
    input logic flag,
    input logic hold
  );
    return enable & (flag | hold);
  endfunction
  // ------------------------------------------------------------
  // comparator synchronisers
  // ------------------------------------------------------------
  // over-power enable comparator
  level_sync u_sync_ovd_en (
    .clk    (clk),
    .resetn (resetn),
    .din    (ovd_above_en),
    .dout   (ovd_en_s)
  );
  // over-power release comparator
  level_sync u_sync_ovd_dis (
    .clk    (clk),
    .resetn (resetn),
    .din    (ovd_above_dis),
    .dout   (ovd_dis_s)
  );
  // clamp enable comparator
  level_sync u_sync_ovp_en (
    .clk    (clk),
    .resetn (resetn),
    .din    (ovp_above_en),
    .dout   (ovp_en_s)
  );
  // clamp release comparator
  level_sync u_sync_ovp_dis (
    .clk    (clk),
    .resetn (resetn),
    .din    (ovp_above_dis),
    .dout   (ovp_dis_s)
  );
  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  // over-power detect flag
  sticky_flag u_ovd_flag (
    .clk    (clk),
    .resetn (resetn),
    .port   (ovd_f.owner)
  );
  // over-voltage clamp flag
  sticky_flag u_ovp_flag (
    .clk    (clk),
    .resetn (resetn),
    .port   (ovp_f.owner)
  );
  // read of the upper status register with auto clear on
  assign auto_clr = auto_status_clear & upper_status_read;
  // over-power flag set only on an armed rising edge
  assign ovd_f.set_evt = rose_now(ovd_en_s, s_q.ovd_en_prev) & (s_q.arm == ARM_IDLE);
  assign ovd_f.clr     = over_power_flag_clear | auto_clr;
  // clamp flag set while above clamp threshold
  assign ovp_f.set_evt = ovp_en_s;
  assign ovp_f.clr     = clamp_flag_clear | auto_clr;
  // clamp flag rising edge, drives the buck auto disable
  assign clamp_rise    = rose_now(ovp_f.flag, s_q.clamp_flag_prev);
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    // start from the held state
    s_d             = s_q;
    // registered copies for edge detection
    s_d.ovd_en_prev = ovd_en_s;
    s_d.clamp_flag_prev = ovp_f.flag;
    // over-power and clamp holds with hysteresis
    s_d.ovd_hold   = hyst_next(s_q.ovd_hold, ovd_en_s, ovd_dis_s);
    s_d.clamp_hold = hyst_next(s_q.clamp_hold, ovp_en_s, ovp_dis_s);
    // re-arm only after release then fresh crossing
    s_d.arm        = arm_next(s_q.arm, ovd_f.set_evt, ovd_f.flag, ovd_dis_s);
    // buck enable: host write, auto disable on clamp rise
    s_d.buck_en    = buck_next(s_q.buck_en, buck_enable_wr, buck_enable_wdata, clamp_rise,
                               converter_ov_disable_enable, clamp_irq_enable);
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // state register, async reset to constants
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.arm             <= ARM_IDLE;
      s_q.ovd_en_prev     <= 1'b0;
      s_q.ovd_hold        <= 1'b0;
      s_q.clamp_hold      <= 1'b0;
      s_q.buck_en         <= `BUCK_EN_RESET;
      s_q.clamp_flag_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign over_power_flag       = ovd_f.flag;
  assign clamp_flag            = ovp_f.flag;
  assign buck_converter_enable = s_q.buck_en;
  assign ldo_enable            = `LDO_EN_RESET;
  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // open-drain tune pins drive low, enable low while pulling
  assign tune_pin_a_out   = 1'b0;
  assign tune_pin_b_out   = 1'b0;
  // per-pin copies of the tune hold and the clamp short
  for (genvar g = 0; g < 2; g++) begin : g_pin
    assign tune_oe_n_v[g] = ~s_q.ovd_hold;
    assign ac_short_v[g]  = s_q.clamp_hold;
  end
  // pin a and pin b
  assign tune_pin_a_oe_n  = tune_oe_n_v[0];
  assign tune_pin_b_oe_n  = tune_oe_n_v[1];
  assign ac_input_a_short = ac_short_v[0];
  assign ac_input_b_short = ac_short_v[1];
  // ------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------
  // interrupt causes: enabled source flagged, or enabled source held until released
  assign op_cause    = irq_cause(over_power_irq_enable, ovd_f.flag, s_q.ovd_hold);
  assign clamp_cause = irq_cause(clamp_irq_enable, ovp_f.flag, s_q.clamp_hold);
  // open-drain line: enable low while any cause is pending
  assign irq_n_out   = 1'b0;
  assign irq_n_oe_n  = ~(op_cause | clamp_cause);
endmodule

// >>> verilog/ovp_irq_regs.svh
// constants for the over-voltage protection event and interrupt logic
`ifndef OVP_IRQ_REGS_SVH
`define OVP_IRQ_REGS_SVH
`define SYNC_STAGES      2
`define FLAG_RESET       1'b0
`define OV_DIS_RESET     1'b0
`define BUCK_EN_RESET    1'b0
`define LDO_EN_RESET     1'b1
`endif

// >>> verilog/ovp_irq_pkg.sv
// types shared by the over-voltage protection event and interrupt logic
package ovp_irq_pkg;
  typedef enum logic [1:0] {
    ARM_IDLE,
    ARM_PENDING,
    ARM_WAIT_LOW
  } arm_state_t;
endpackage

// >>> verilog/flag_if.sv
// flag event, clear and pending bundle between the top and the flag cells
`timescale 1ns/100ps
interface flag_if;
  logic set_evt;
  logic clr;
  logic flag;
  modport owner (input set_evt, input clr, output flag);
  modport user  (output set_evt, output clr, input flag);
endinterface

// >>> verilog/level_sync.sv
// two flip-flop synchroniser for one comparator level
`timescale 1ns/100ps
`include "ovp_irq_regs.svh"
module level_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [`SYNC_STAGES-1:0] sh;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;
  // shift chain, first stage read only by the second
  always_comb begin
    s_d    = s_q;
    s_d.sh = {s_q.sh[`SYNC_STAGES-2:0], din};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign dout = s_q.sh[`SYNC_STAGES-1];
endmodule

// >>> verilog/sticky_flag.sv
// sticky status flag, set beats clear
`timescale 1ns/100ps
`include "ovp_irq_regs.svh"
module sticky_flag (
  input  wire logic clk,
  input  wire logic resetn,
  flag_if.owner     port
);
  typedef struct packed {
    logic flag;
  } flag_state_t;
  flag_state_t s_q;
  flag_state_t s_d;
  // set wins over a clear in the same cycle
  always_comb begin
    s_d = s_q;
    if (port.clr) begin
      s_d.flag = 1'b0;
    end
    if (port.set_evt) begin
      s_d.flag = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.flag <= `FLAG_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  assign port.flag = s_q.flag;
endmodule

// >>> verif/host_model.sv
// host side model of the pulled-up interrupt line
`timescale 1ns/100ps
module host_model (
  input  wire logic irq_n_out,
  input  wire logic irq_n_oe_n,
  output logic      irq_pin
);
  // pull-up wins while the device releases the line
  assign irq_pin = irq_n_oe_n ? 1'h1 : irq_n_out;
endmodule

// >>> verif/ovp_checker_properties.sv
// concurrent checks on the protection and interrupt ports
`timescale 1ns/100ps
module ovp_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ovd_above_en,
  input wire logic ovd_above_dis,
  input wire logic ovp_above_en,
  input wire logic over_power_irq_enable,
  input wire logic clamp_irq_enable,
  input wire logic over_power_flag_clear,
  input wire logic auto_status_clear,
  input wire logic upper_status_read,
  input wire logic converter_ov_disable_enable,
  input wire logic over_power_flag,
  input wire logic clamp_flag,
  input wire logic buck_converter_enable,
  input wire logic tune_pin_a_oe_n,
  input wire logic tune_pin_b_oe_n,
  input wire logic ac_input_a_short,
  input wire logic irq_n_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------
  // properties
  // ----------
  property p_tune_on; $rose(ovd_above_en) |-> ##[1:4] !tune_pin_a_oe_n && !tune_pin_b_oe_n; endproperty
  a_tune_on: assert property (p_tune_on) else $error("tune pins not pulled");
  property p_op_irq; over_power_flag && over_power_irq_enable |-> !irq_n_oe_n; endproperty
  a_op_irq: assert property (p_op_irq) else $error("irq not asserted");
  property p_irq_idle;
    !over_power_flag && !clamp_flag && tune_pin_a_oe_n && !ac_input_a_short |-> irq_n_oe_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq without cause");
  // a pin rise seen 3 then 2 edges back reaches the flag at this edge
  property p_op_clr;
    over_power_flag_clear && !($past(ovd_above_en, 2) && !$past(ovd_above_en, 3)) |=> !over_power_flag;
  endproperty
  a_op_clr: assert property (p_op_clr) else $error("flag not cleared");
  property p_auto_clr;
    auto_status_clear && upper_status_read && !$past(ovp_above_en, 2)
      && !($past(ovd_above_en, 2) && !$past(ovd_above_en, 3)) |=> !clamp_flag && !over_power_flag;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("read did not clear");
  property p_clamp_on; $rose(ovp_above_en) |-> ##[1:4] clamp_flag && ac_input_a_short; endproperty
  a_clamp_on: assert property (p_clamp_on) else $error("clamp missing");
  property p_tune_off; !ovd_above_dis [*4] |-> tune_pin_a_oe_n && tune_pin_b_oe_n; endproperty
  a_tune_off: assert property (p_tune_off) else $error("tune hold stuck");
  property p_buck_off;
    $rose(clamp_flag) && converter_ov_disable_enable && clamp_irq_enable |=> !buck_converter_enable;
  endproperty
  a_buck_off: assert property (p_buck_off) else $error("buck not disabled");
endmodule
bind overvoltage_protect_irq ovp_checker chk_u (.*);

// >>> verif/tb_top.sv
// self-checking bench for the protection interrupt logic
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'h0, resetn = 1'h0, ovd_above_en = 1'h0, ovd_above_dis = 1'h0, ovp_above_en = 1'h0;
  logic ovp_above_dis = 1'h0, over_power_irq_enable = 1'h0, clamp_irq_enable = 1'h0, over_power_flag_clear = 1'h0;
  logic clamp_flag_clear = 1'h0, auto_status_clear = 1'h0, upper_status_read = 1'h0;
  logic converter_ov_disable_enable = 1'h0, buck_enable_wr = 1'h0, buck_enable_wdata = 1'h0;
  logic over_power_flag, clamp_flag, buck_converter_enable, ldo_enable, tune_pin_a_out, tune_pin_a_oe_n;
  logic tune_pin_b_out, tune_pin_b_oe_n, ac_input_a_short, ac_input_b_short, irq_n_out, irq_n_oe_n, irq_pin;
  int miscompares = 0, tests_run = 0;
  always #50 clk = ~clk;
  overvoltage_protect_irq dut_u (.*);
  host_model host_u (.irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n), .irq_pin(irq_pin));
  // -------
  // helpers
  // -------
  task automatic tick(int n); repeat (n) @(posedge clk); endtask
  task automatic look; @(negedge clk); endtask
  task automatic chk(logic got, logic exp, string msg);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic t_over_power;
    look; chk(buck_converter_enable, 1'h0, "buck reset");
    tick(1); over_power_irq_enable <= 1'h1; ovd_above_dis <= 1'h1; ovd_above_en <= 1'h1;
    tick(6); look; chk(over_power_flag, 1'h1, "op flag");
    chk(tune_pin_a_oe_n | tune_pin_b_oe_n, 1'h0, "tune hold");
    chk(tune_pin_a_out | tune_pin_b_out, 1'h0, "tune drive");
    chk(irq_pin, 1'h0, "op irq");
    tick(1); over_power_flag_clear <= 1'h1; tick(1); over_power_flag_clear <= 1'h0;
    ovd_above_en <= 1'h0; tick(6); ovd_above_en <= 1'h1; tick(6); look;
    chk(over_power_flag, 1'h0, "op re-set");
    chk(irq_pin, 1'h0, "irq held");
    chk(tune_pin_b_oe_n, 1'h0, "hold kept");
    tick(1); ovd_above_dis <= 1'h0; ovd_above_en <= 1'h0; tick(6); look;
    chk(tune_pin_a_oe_n & tune_pin_b_oe_n, 1'h1, "hold off");
    chk(irq_pin, 1'h1, "irq off");
    tick(1); ovd_above_dis <= 1'h1; ovd_above_en <= 1'h1; tick(6); look;
    chk(over_power_flag, 1'h1, "op re-armed");
    tick(1); auto_status_clear <= 1'h1; upper_status_read <= 1'h1; tick(1); upper_status_read <= 1'h0;
    tick(1); look; chk(over_power_flag, 1'h0, "auto clear");
    tick(1); ovd_above_dis <= 1'h0; ovd_above_en <= 1'h0; auto_status_clear <= 1'h0; tick(6);
  endtask
  task automatic t_clamp_buck;
    clamp_irq_enable <= 1'h1; converter_ov_disable_enable <= 1'h1; buck_enable_wr <= 1'h1; buck_enable_wdata <= 1'h1;
    tick(1); buck_enable_wr <= 1'h0; tick(2); look; chk(buck_converter_enable, 1'h1, "buck on");
    tick(1); ovp_above_dis <= 1'h1; ovp_above_en <= 1'h1; tick(6); look;
    chk(clamp_flag, 1'h1, "clamp flag");
    chk(ac_input_a_short & ac_input_b_short, 1'h1, "shorts on");
    chk(irq_pin, 1'h0, "clamp irq");
    chk(buck_converter_enable, 1'h0, "buck off");
    chk(ldo_enable, 1'h1, "ldo on");
    tick(1); ovp_above_en <= 1'h0; ovp_above_dis <= 1'h0; tick(6); look;
    chk(ac_input_a_short | ac_input_b_short, 1'h0, "shorts off");
    tick(1); clamp_flag_clear <= 1'h1; buck_enable_wr <= 1'h1; tick(1); clamp_flag_clear <= 1'h0; buck_enable_wr <= 1'h0;
    tick(2); look; chk(clamp_flag, 1'h0, "clamp clear");
    chk(buck_converter_enable, 1'h1, "buck restart");
    chk(irq_pin, 1'h1, "irq released");
  endtask
  task automatic t_keep_buck;
    tick(1); converter_ov_disable_enable <= 1'h0; auto_status_clear <= 1'h1;
    ovp_above_dis <= 1'h1; ovp_above_en <= 1'h1;
    tick(6); look; chk(buck_converter_enable, 1'h1, "buck kept");
    tick(1); ovp_above_en <= 1'h0; ovp_above_dis <= 1'h0; tick(6); upper_status_read <= 1'h1;
    tick(1); upper_status_read <= 1'h0; tick(1); look;
    chk(clamp_flag, 1'h0, "clamp auto");
    chk(irq_pin, 1'h1, "irq auto");
  endtask
  initial begin
    tick(10); resetn <= 1'h1;
    t_over_power; t_clamp_buck; t_keep_buck;
    end_sim;
  end
  // hang guard
  initial begin #1000000; miscompares++; end_sim; end
endmodule
